// ==== rtl/ivo_pkg.sv ====
// Package of constants and types for the interrupt vector offset and flag block.
// Operation
// - Offset field bits 17:16 and 15:1, rest zero.
// - Every offset register resets to zero.
// - Ordinary registers get clear, set, invert aliases.
// - Offset registers have no aliases.
// - Enabled peripheral event sets its flag.
// - Flag setting ignores the interrupt enable.
// - Flags stay set until software clears.
// - Up to 216 sources, each own flag; 9 vector offsets.
package ivo_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_SRC = 216;
  localparam int unsigned NUM_OFF = 9;
  localparam int unsigned FLAG_WORDS = 7;
  localparam int unsigned OFF_W = 18;
  localparam int unsigned OFF_LSB = 1;
  localparam int unsigned OFF_MSB = 17;
  localparam logic [DATA_W-1:0] OFF_MASK = 32'h0003FFFE;
  localparam logic [DATA_W-1:0] OFF_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] FLAG_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] EN_RESET = 32'h00000000;
  // Alias offsets relative to a register's own address.
  localparam logic [ADDR_W-1:0] ALIAS_CLR = 16'h0004;
  localparam logic [ADDR_W-1:0] ALIAS_SET = 16'h0008;
  localparam logic [ADDR_W-1:0] ALIAS_INV = 16'h000C;
  // Flag status words, 0x10 apart so each keeps room for its three aliases.
  localparam logic [ADDR_W-1:0] FLAG_BASE = 16'h0040;
  localparam logic [ADDR_W-1:0] ENABLE_BASE = 16'h00C0;
  localparam logic [ADDR_W-1:0] REG_STRIDE = 16'h0010;
  // Vector offset registers with their numbers.
  localparam logic [ADDR_W-1:0] OFF_ADDR [NUM_OFF] = '{
    16'h0800, 16'h0808, 16'h08D0, 16'h08D4, 16'h0910,
    16'h0914, 16'h0918, 16'h0938, 16'h8080};
  localparam logic [7:0] OFF_VEC [NUM_OFF] = '{
    8'hE3, 8'hE2, 8'hE4, 8'hE5, 8'hF4, 8'hF5, 8'hF6, 8'hFE, 8'hE6};
  typedef enum logic [3:0] {
    IVO_OP_NONE = 4'h1,
    IVO_OP_CLR = 4'h2,
    IVO_OP_SET = 4'h4,
    IVO_OP_INV = 4'h8
  } ivo_op_e;
endpackage : ivo_pkg

// ==== rtl/ivo_off_mem.sv ====
// Memory of vector offsets with a registered entry lookup port.
`timescale 1ns/1ns
module ivo_off_mem (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [3:0] wr_idx_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [3:0] rd_idx_i,
  output logic [31:0] rd_data_o,
  input wire logic [3:0] take_idx_i,
  output logic [31:0] take_data_o
);
  typedef struct packed {
    logic [ivo_pkg::NUM_OFF-1:0][31:0] mem;
    logic [31:0] rd;
    logic [31:0] take;
  } ivo_mem_s;
  ivo_mem_s st_r;
  ivo_mem_s st_nxt;
  // Write masks unimplemented bits so reads give zero there; ports read registered.
  always_comb begin
    st_nxt = st_r;
    if (wr_i && wr_idx_i < 4'(ivo_pkg::NUM_OFF)) begin
      st_nxt.mem[wr_idx_i] = wr_data_i & ivo_pkg::OFF_MASK;
    end
    st_nxt.rd = (rd_idx_i < 4'(ivo_pkg::NUM_OFF)) ? st_r.mem[rd_idx_i] : 32'h00000000;
    st_nxt.take = (take_idx_i < 4'(ivo_pkg::NUM_OFF)) ?
                  (st_r.mem[take_idx_i] & ivo_pkg::OFF_MASK) : 32'h00000000;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign rd_data_o = st_r.rd;
  assign take_data_o = st_r.take;
endmodule : ivo_off_mem

// ==== rtl/ivo_flag_word.sv ====
// One 32-bit interrupt flag status word with sticky set and alias updates.
`timescale 1ns/1ns
module ivo_flag_word (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] event_i,
  input wire logic [31:0] periph_en_i,
  input wire logic wr_i,
  input wire logic [3:0] op_i,
  input wire logic [31:0] wr_data_i,
  output logic [31:0] flag_o
);
  typedef struct packed {
    logic [31:0] flag;
  } ivo_fw_s;
  ivo_fw_s st_r;
  ivo_fw_s st_nxt;
  // Software update first, then hardware set on top so a coincident event wins.
  always_comb begin
    st_nxt = st_r;
    if (wr_i) begin
      case (op_i)
        ivo_pkg::IVO_OP_CLR: st_nxt.flag = st_r.flag & ~wr_data_i;
        ivo_pkg::IVO_OP_SET: st_nxt.flag = st_r.flag | wr_data_i;
        ivo_pkg::IVO_OP_INV: st_nxt.flag = st_r.flag ^ wr_data_i;
        default: st_nxt.flag = wr_data_i;
      endcase
    end
    // Interrupt enable plays no part; only peripheral enable and event do.
    st_nxt.flag = st_nxt.flag | (event_i & periph_en_i);
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign flag_o = st_r.flag;
endmodule : ivo_flag_word

// ==== rtl/ivo_top.sv ====
// Top of the interrupt vector offset and flag status block with register port.
`timescale 1ns/1ns
module ivo_top (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [215:0] event_i,
  input wire logic [215:0] periph_en_i,
  input wire logic take_i,
  input wire logic [7:0] take_vec_i,
  output logic [215:0] flag_o,
  output logic [17:0] entry_off_o,
  output logic entry_valid_o
);
  localparam int unsigned FW = ivo_pkg::FLAG_WORDS;
  typedef struct packed {
    logic [31:0] rdata;
    logic [1:0] rd_sel;
    logic [2:0] rd_word;
    logic [FW*32-1:0] en;
    logic take_d;
    logic [17:0] entry;
    logic entry_v;
  } ivo_top_s;
  ivo_top_s st_r;
  ivo_top_s st_nxt;
  logic [FW*32-1:0] ev_w;
  logic [FW*32-1:0] pe_w;
  logic [FW-1:0][31:0] flag_w;
  logic [FW-1:0] fwr;
  logic [3:0] op;
  logic off_hit;
  logic [4:0] off_lu;
  logic [3:0] off_idx;
  logic [3:0] take_idx;
  logic [31:0] off_rd;
  logic [31:0] off_take;

  // Decode an offset register address; aliases of it never match.
  function automatic logic [4:0] off_lookup(input logic [15:0] a);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < int'(ivo_pkg::NUM_OFF); i++) begin
      if (a == ivo_pkg::OFF_ADDR[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : off_lookup

  // Map a vector number to its offset slot, or none.
  function automatic logic [3:0] vec_lookup(input logic [7:0] v);
    logic [3:0] r;
    r = 4'hF;
    for (int i = 0; i < int'(ivo_pkg::NUM_OFF); i++) begin
      if (v == ivo_pkg::OFF_VEC[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : vec_lookup

  // Alias operation from the low nibble of an ordinary register's address.
  function automatic logic [3:0] alias_op(input logic [15:0] a);
    logic [15:0] low;
    low = a & 16'h000F;
    if (low == ivo_pkg::ALIAS_CLR) begin
      return ivo_pkg::IVO_OP_CLR;
    end else if (low == ivo_pkg::ALIAS_SET) begin
      return ivo_pkg::IVO_OP_SET;
    end else if (low == ivo_pkg::ALIAS_INV) begin
      return ivo_pkg::IVO_OP_INV;
    end else begin
      return ivo_pkg::IVO_OP_NONE;
    end
  endfunction : alias_op

  // Word index within a group of ordinary registers, or 7 when outside it.
  function automatic logic [2:0] word_of(input logic [15:0] a, input logic [15:0] base);
    logic [15:0] d;
    d = a - base;
    if (a >= base && d < 16'(FW * 16)) begin
      return d[6:4];
    end else begin
      return 3'h7;
    end
  endfunction : word_of

  assign ev_w = (FW*32)'(event_i);
  assign pe_w = (FW*32)'(periph_en_i);
  assign op = alias_op(addr_i);
  // The lookup result is held in a net, since a function result cannot be sliced.
  assign off_lu = off_lookup(addr_i);
  assign off_hit = off_lu[4];
  assign off_idx = off_lu[3:0];
  assign take_idx = vec_lookup(take_vec_i);

  // One flag word per 32 sources; the last word's upper bits have no source.
  generate
    for (genvar g = 0; g < FW; g++) begin : g_flag
      assign fwr[g] = wr_i && !off_hit && word_of(addr_i, ivo_pkg::FLAG_BASE) == 3'(g);
      ivo_flag_word u_word (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .event_i(ev_w[g*32 +: 32]),
        .periph_en_i(pe_w[g*32 +: 32]),
        .wr_i(fwr[g]),
        .op_i(op),
        // Bits of the last word without a source must stay zero under any write.
        .wr_data_i((g == FW - 1) ? {8'h00, wdata_i[23:0]} : wdata_i),
        .flag_o(flag_w[g])
      );
    end
  endgenerate

  // Offset store; writes only land at the register's own address.
  ivo_off_mem u_off (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_i && off_hit),
    .wr_idx_i(off_idx),
    .wr_data_i(wdata_i),
    .rd_idx_i(off_hit ? off_idx : 4'hF),
    .rd_data_o(off_rd),
    .take_idx_i(take_idx),
    .take_data_o(off_take)
  );

  // Register port, enable words and entry formation.
  always_comb begin
    logic [2:0] w;
    logic [31:0] cur;
    w = word_of(addr_i, ivo_pkg::ENABLE_BASE);
    cur = 32'h00000000;
    st_nxt = st_r;
    st_nxt.rd_sel = 2'h0;
    st_nxt.rd_word = 3'h7;
    st_nxt.rdata = 32'h00000000;
    if (wr_i && !off_hit && w != 3'h7) begin
      cur = st_r.en[w*32 +: 32];
      case (op)
        ivo_pkg::IVO_OP_CLR: cur = cur & ~wdata_i;
        ivo_pkg::IVO_OP_SET: cur = cur | wdata_i;
        ivo_pkg::IVO_OP_INV: cur = cur ^ wdata_i;
        default: cur = wdata_i;
      endcase
      st_nxt.en[w*32 +: 32] = cur;
    end
    // Reads of aliases return the base register; unmapped reads return zero.
    if (rd_i) begin
      if (off_hit) begin
        st_nxt.rd_sel = 2'h1;
      end else if (word_of(addr_i, ivo_pkg::FLAG_BASE) != 3'h7) begin
        st_nxt.rd_sel = 2'h2;
        st_nxt.rd_word = word_of(addr_i, ivo_pkg::FLAG_BASE);
        // Captured at the read edge, so flags read as they stood when the strobe was taken.
        st_nxt.rdata = flag_w[word_of(addr_i, ivo_pkg::FLAG_BASE)];
      end else if (w != 3'h7) begin
        st_nxt.rd_sel = 2'h3;
        st_nxt.rd_word = w;
        st_nxt.rdata = st_r.en[w*32 +: 32];
      end
    end
    // The offset lookup is registered, so the entry follows the request by two cycles.
    st_nxt.take_d = take_i && take_idx != 4'hF;
    st_nxt.entry_v = st_r.take_d;
    if (st_r.take_d) begin
      st_nxt.entry = {off_take[17:1], 1'b0};
    end
  end

  // Read data mux sits one cycle behind the strobe to line up with the offset memory.
  always_comb begin
    case (st_r.rd_sel)
      2'h1: rdata_o = off_rd;
      2'h2: rdata_o = st_r.rdata;
      2'h3: rdata_o = st_r.rdata;
      default: rdata_o = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  generate
    for (genvar g = 0; g < FW; g++) begin : g_out
      if (g < FW - 1) begin : g_full
        assign flag_o[g*32 +: 32] = flag_w[g];
      end else begin : g_tail
        assign flag_o[215:192] = flag_w[g][23:0];
      end
    end
  endgenerate
  assign entry_off_o = st_r.entry;
  assign entry_valid_o = st_r.entry_v;
endmodule : ivo_top

// ==== dv/ivo_checker.sv ====
// Concurrent checks on the ports of the vector offset and flag block.
`timescale 1ns/1ns
module ivo_checker (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [215:0] event_i,
  input wire logic [215:0] periph_en_i,
  input wire logic take_i,
  input wire logic [215:0] flag_o,
  input wire logic [17:0] entry_off_o,
  input wire logic entry_valid_o
);
  // One clock domain, so clock and reset are stated once.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Pages 0x08 and 0x09 hold only offset registers.
  property p_off_bits;
    rd_i && addr_i[15:9] == 7'h04 |=> (rdata_o & ~ivo_pkg::OFF_MASK) == '0;
  endproperty
  a_off_bits: assert property (p_off_bits) else $error("unused offset bits set");
  property p_flag_read;
    rd_i && addr_i == 16'h0040 |=> rdata_o == $past(flag_o[31:0]);
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag word read wrong");
  property p_set;
    !wr_i |=> (flag_o & $past(event_i & periph_en_i)) == $past(event_i & periph_en_i);
  endproperty
  a_set: assert property (p_set) else $error("enabled event left flag low");
  property p_no_spont;
    !$past(wr_i) |-> (flag_o & ~$past(flag_o) & ~$past(event_i & periph_en_i)) == '0;
  endproperty
  a_no_spont: assert property (p_no_spont) else $error("flag rose without cause");
  property p_sticky;
    !$past(wr_i) |-> (~flag_o & $past(flag_o)) == '0;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without write");
  property p_entry_late;
    entry_valid_o |-> $past(take_i, 2);
  endproperty
  a_entry_late: assert property (p_entry_late) else $error("entry pulse not 2 after take");
  property p_entry_lsb;
    entry_valid_o |-> !entry_off_o[0];
  endproperty
  a_entry_lsb: assert property (p_entry_lsb) else $error("entry offset bit 0 set");
  property p_entry_hold;
    !$past(take_i, 2) |-> $stable(entry_off_o);
  endproperty
  a_entry_hold: assert property (p_entry_hold) else $error("entry offset moved");
  // Main scenarios that the bench must reach.
  c_take: cover property (entry_valid_o);
  c_inv: cover property (wr_i && addr_i == 16'h004C);
  c_far: cover property (rd_i && addr_i == 16'h8080);
endmodule : ivo_checker
bind ivo_top ivo_checker ivo_checker_inst (.*);

// ==== dv/ivo_cpu_model.sv ====
// Bus master model of the processor side on the register port.
`timescale 1ns/1ns
module ivo_cpu_model (
  input wire logic mclk_i,
  output logic [15:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // Bus idles until the first access.
  initial begin
    addr_o = 16'h0000;
    wdata_o = 32'h00000000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Strobes last one cycle; the idle cycle after each keeps drivers apart.
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
  endtask : rd
endmodule : ivo_cpu_model

// ==== dv/ivo_top_test.sv ====
// Self-checking testbench of the vector offset and flag block.
`timescale 1ns/1ns
module ivo_top_test;
  logic mclk_i, rst_n_i, wr_i, rd_i, take_i, entry_valid_o, rd_q;
  logic [15:0] addr_i;
  logic [31:0] wdata_i, rdata_o, fexp, r, m;
  logic [7:0] take_vec_i;
  logic [215:0] event_i, periph_en_i, flag_o;
  logic [17:0] entry_off_o;
  logic [31:0] rq[$];
  logic [17:0] eq[$];
  logic [31:0] offs[9];
  int failures = 0, checks = 0, seed = 70738;
  ivo_top ivo_top_inst (.*);
  ivo_cpu_model ivo_cpu_model_inst (.mclk_i(mclk_i), .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i));
  // Free-running 100 MHz clock.
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_entry(input logic [17:0] got, input logic [17:0] exp);
    cmp_word({14'h0000, got}, {14'h0000, exp});
  endtask : cmp_entry
  task automatic take(input logic [7:0] v);
    @(posedge mclk_i);
    take_i <= 1'b1;
    take_vec_i <= v;
    @(posedge mclk_i);
    take_i <= 1'b0;
  endtask : take
  task automatic report_and_stop;
    // A note left unanswered means a result never appeared.
    if (rq.size() != 0 || eq.size() != 0) begin
      failures++;
    end
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  // Results are matched to the oldest note; a pulse with no note can never match.
  always @(posedge mclk_i) begin
    if (rd_q === 1'b1) cmp_word(rdata_o, rq.pop_front());
    if (entry_valid_o === 1'b1) cmp_entry(entry_off_o, eq.size() ? eq.pop_front() : 18'h3FFFF);
    rd_q <= rd_i;
  end
  // Cuts a hang short well beyond the roughly 150 cycles the tests need.
  initial begin
    #20000;
    failures++;
    report_and_stop();
  end
  initial begin
    rst_n_i = 1'b0;
    take_i = 1'b0;
    take_vec_i = 8'h00;
    event_i = '0;
    periph_en_i = '0;
    rd_q = 1'b0;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    // Reset value, then random offsets with ones written into the unused bits.
    for (int i = 0; i < 9; i++) begin
      rq.push_back(32'h00000000);
      ivo_cpu_model_inst.rd(ivo_pkg::OFF_ADDR[i]);
      offs[i] = $random(seed) & ivo_pkg::OFF_MASK;
      ivo_cpu_model_inst.wr(ivo_pkg::OFF_ADDR[i], offs[i] | ~ivo_pkg::OFF_MASK);
    end
    // The last register has free alias addresses; writes there must not land.
    for (int a = 1; a < 4; a++) ivo_cpu_model_inst.wr(16'h8080 + 16'(4 * a), 32'hFFFFFFFF);
    // Each vector keeps its own offset and yields it on a take.
    for (int i = 0; i < 9; i++) begin
      rq.push_back(offs[i]);
      ivo_cpu_model_inst.rd(ivo_pkg::OFF_ADDR[i]);
      eq.push_back(offs[i][17:0]);
      take(ivo_pkg::OFF_VEC[i]);
    end
    take(8'h10);
    rq.push_back(32'h00000000);
    ivo_cpu_model_inst.rd(16'h0600);
    $display("test offsets done");
    // Random events with random peripheral enables, then clear, set and invert aliases.
    fexp = 32'h00000000;
    for (int k = 0; k < 6; k++) begin
      r = $random(seed);
      m = $random(seed);
      @(posedge mclk_i);
      event_i[31:0] <= r;
      periph_en_i[31:0] <= m;
      @(posedge mclk_i);
      event_i[31:0] <= 32'h00000000;
      fexp = fexp | (r & m);
      rq.push_back(fexp);
      ivo_cpu_model_inst.rd(ivo_pkg::FLAG_BASE);
      r = $random(seed);
      case (k % 3)
        0: fexp = fexp & ~r;
        1: fexp = fexp | r;
        default: fexp = fexp ^ r;
      endcase
      ivo_cpu_model_inst.wr(ivo_pkg::FLAG_BASE + 16'((k % 3) * 4 + 4), r);
      @(posedge mclk_i);
      cmp_word(flag_o[31:0], fexp);
    end
    // Enable words keep their own value and aliases, apart from the flags.
    ivo_cpu_model_inst.wr(ivo_pkg::ENABLE_BASE, r);
    ivo_cpu_model_inst.wr(ivo_pkg::ENABLE_BASE + ivo_pkg::ALIAS_INV, m);
    rq.push_back(r ^ m);
    ivo_cpu_model_inst.rd(ivo_pkg::ENABLE_BASE);
    // Sources 160 to 191 reach their own flags; the tail bits of the last word stay zero.
    @(posedge mclk_i);
    event_i <= '1;
    periph_en_i <= '1;
    @(posedge mclk_i);
    event_i <= '0;
    ivo_cpu_model_inst.wr(ivo_pkg::FLAG_BASE + 16'h0060 + ivo_pkg::ALIAS_SET, 32'hFFFFFFFF);
    rq.push_back(32'h00FFFFFF);
    ivo_cpu_model_inst.rd(ivo_pkg::FLAG_BASE + 16'h0060);
    @(posedge mclk_i);
    cmp_word(flag_o[191:160], 32'hFFFFFFFF);
    cmp_word({8'h00, flag_o[215:192]}, 32'h00FFFFFF);
    $display("test flags done");
    repeat (4) @(posedge mclk_i);
    report_and_stop();
  end
endmodule : ivo_top_test
